// >>> common/nmh_pkg.sv
/*
  Shared constants and types for the negative multiply-accumulate
  high-halfword unit: register map, field positions, reset values, carriers.
  Assumes one 50 MHz clock with a synchronous active-high reset.
*/
// What this block does
// RULE1 - take upper halfword of both sources
// RULE2 - signed 16x16 multiply, 32-bit product
// RULE3 - subtract product from destination, 33 bits
// RULE4 - store low 32 bits when no saturation
// RULE5 - saturating variants store nearest representable value
// RULE6 - base variants leave flags and condition untouched
// RULE7 - record variants update condition field only
// RULE8 - overflow variants update overflow flags only
// RULE9 - overflow plus record updates both
// RULE10 - overflow flag per range, summary sticky, clamp
// RULE11 - condition bits from sign, zero, summary
package nmh_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] NMH_OFF_SRC1 = 8'h00;
  localparam logic [7:0] NMH_OFF_SRC2 = 8'h04;
  localparam logic [7:0] NMH_OFF_DEST = 8'h08;
  localparam logic [7:0] NMH_OFF_CTRL = 8'h0c;
  localparam logic [7:0] NMH_OFF_FLAG = 8'h10;
  localparam logic [7:0] NMH_OFF_COND = 8'h14;
  localparam logic [7:0] NMH_OFF_IST = 8'h18;
  localparam logic [7:0] NMH_OFF_IEN = 8'h1c;
  localparam logic [7:0] NMH_OFF_ICLR = 8'h20;
  // control register fields; a write with go set launches an operation
  localparam int NMH_CTRL_GO = 0;
  localparam int NMH_CTRL_SAT = 1;
  localparam int NMH_CTRL_OVE = 2;
  localparam int NMH_CTRL_REC = 3;
  // flag register fields
  localparam int NMH_FLAG_SO = 0;
  localparam int NMH_FLAG_OV = 1;
  // interrupt status fields
  localparam int NMH_IRQ_DONE = 0;
  localparam int NMH_IRQ_OVF = 1;
  localparam int NMH_IRQ_W = 2;
  // reset values
  localparam logic [31:0] NMH_RST_WORD = 32'h0000_0000;
  localparam logic [3:0] NMH_RST_COND = 4'h0;
  // saturation limits
  localparam logic [31:0] NMH_SAT_POS = 32'h7fff_ffff;
  localparam logic [31:0] NMH_SAT_NEG = 32'h8000_0000;
  // condition field bit positions: lt gt eq so, msb first
  localparam int NMH_CR_LT = 3;
  localparam int NMH_CR_GT = 2;
  localparam int NMH_CR_EQ = 1;
  localparam int NMH_CR_SO = 0;

  // operation options travel together
  typedef struct packed {
    logic sat;
    logic ove;
    logic rec;
  } nmh_opt_t;

  // datapath answer
  typedef struct packed {
    logic [31:0] result;
    logic ovf;
  } nmh_res_t;
endpackage

// >>> src/nmh_datapath.sv
/*
  Combinational datapath: high-halfword signed multiply, subtract from the
  destination, optional saturation. Assumes operands are held stable.
*/
`timescale 1ns/1ps
module nmh_datapath
  import nmh_pkg::*;
(
  input wire logic [31:0] src1,
  input wire logic [31:0] src2,
  input wire logic [31:0] dest,
  input wire logic sat,
  output nmh_res_t res
);
  logic signed [15:0] half_a;
  logic signed [15:0] half_b;
  logic signed [31:0] prod;
  logic signed [32:0] diff;
  logic out_of_range;

  // big-endian bits 0..15 are the upper halfword here [RULE1]
  assign half_a = src1[31:16]; // [RULE1]
  assign half_b = src2[31:16];
  // widen on purpose; both casts keep the sign, so the product stays signed
  assign prod = 32'(half_a) * 32'(half_b); // [RULE2]
  // sign-extend both so the 33-bit difference never wraps [RULE3]
  assign diff = {dest[31], dest} - {prod[31], prod}; // [RULE3]
  // bits 32 and 31 disagree exactly when the signed 32-bit range is left
  assign out_of_range = diff[32] ^ diff[31]; // [RULE10]
  assign res.ovf = out_of_range;
  // clamp toward the sign of the true result [RULE5]
  assign res.result = (sat && out_of_range) ? (diff[32] ? NMH_SAT_NEG : NMH_SAT_POS)
                                            : diff[31:0]; // [RULE4] [RULE5] [RULE10]
endmodule

// >>> src/nmh_unit.sv
/*
  Top of the negative multiply-accumulate high-halfword unit with an APB
  register slave and a level interrupt. Assumes one clock domain and a
  32-bit APB master that holds each request until pready.
*/
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module nmh_unit
  import nmh_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);
  logic [31:0] src1_r;
  logic [31:0] src2_r;
  logic [31:0] dest_r;
  logic [31:0] dest_nxt;
  logic so_r;
  logic so_nxt;
  logic ov_r;
  logic ov_nxt;
  logic [3:0] cond_r;
  logic [3:0] cond_nxt;
  nmh_opt_t opt_r;
  logic [NMH_IRQ_W-1:0] ist_r;
  logic [NMH_IRQ_W-1:0] ist_nxt;
  logic [NMH_IRQ_W-1:0] ien_r;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;
  nmh_res_t res;

  // access phase strobes; effects land once, in the first access cycle,
  // because the wait cycle that follows still shows the same request and
  // would otherwise launch a second subtraction from the new destination
  wire access = PSEL && PENABLE;
  wire first_acc = access && !PREADY;
  wire wr = first_acc && PWRITE;
  wire rd = first_acc && !PWRITE;
  wire hit_src1 = PADDR == NMH_OFF_SRC1;
  wire hit_src2 = PADDR == NMH_OFF_SRC2;
  wire hit_dest = PADDR == NMH_OFF_DEST;
  wire hit_ctrl = PADDR == NMH_OFF_CTRL;
  wire hit_flag = PADDR == NMH_OFF_FLAG;
  wire hit_cond = PADDR == NMH_OFF_COND;
  wire hit_ist = PADDR == NMH_OFF_IST;
  wire hit_ien = PADDR == NMH_OFF_IEN;
  wire hit_iclr = PADDR == NMH_OFF_ICLR;
  wire mapped = hit_src1 | hit_src2 | hit_dest | hit_ctrl | hit_flag | hit_cond
                | hit_ist | hit_ien | hit_iclr;
  wire go = wr && hit_ctrl && PWDATA[NMH_CTRL_GO];
  wire sat_w = PWDATA[NMH_CTRL_SAT];
  wire ove_w = PWDATA[NMH_CTRL_OVE];
  wire rec_w = PWDATA[NMH_CTRL_REC];

  // the operation uses the launching write's options, not stale ones
  nmh_datapath u_dp (
    .src1(src1_r),
    .src2(src2_r),
    .dest(dest_r),
    .sat(sat_w),
    .res(res)
  );

  // overflow flags move only for overflow-enabled launches and software flag writes [RULE6] [RULE8] [RULE9]
  wire so_new = so_r | res.ovf; // sticky summary [RULE10]
  assign ov_nxt = (go && ove_w) ? res.ovf : ov_r; // [RULE8] [RULE10]
  assign so_nxt = (go && ove_w) ? so_new : (wr && hit_flag ? PWDATA[NMH_FLAG_SO] : so_r);

  // condition bits from the written value; so bit sees this launch's summary
  wire cr_so = ove_w ? so_new : so_r;
  wire [3:0] cond_calc = {res.result[31], !res.result[31] && (res.result != NMH_RST_WORD),
                          res.result == NMH_RST_WORD, cr_so}; // [RULE11]
  assign cond_nxt = (go && rec_w) ? cond_calc : cond_r; // [RULE7] [RULE9] [RULE6]

  // result lands in the destination; a software write loads the accumulator
  assign dest_nxt = go ? res.result : (wr && hit_dest ? PWDATA : dest_r); // [RULE4] [RULE5]

  // events: done on every launch, overflow on a launch that overflowed;
  // set wins over a clear in the same cycle so no event is lost
  wire [NMH_IRQ_W-1:0] ev = {go && res.ovf, go};
  wire [NMH_IRQ_W-1:0] clr = (wr && hit_iclr) ? PWDATA[NMH_IRQ_W-1:0] : '0;
  assign ist_nxt = (ist_r & ~clr) | ev;

  // read mux; write-only clear register reads as zero
  always_comb begin
    prdata_nxt = NMH_RST_WORD;
    unique case (1'b1)
      hit_src1: prdata_nxt = src1_r;
      hit_src2: prdata_nxt = src2_r;
      hit_dest: prdata_nxt = dest_r;
      hit_ctrl: prdata_nxt = {28'h000_0000, opt_r.rec, opt_r.ove, opt_r.sat, 1'b0};
      hit_flag: prdata_nxt = {30'h0000_0000, ov_r, so_r};
      hit_cond: prdata_nxt = {28'h000_0000, cond_r};
      hit_ist: prdata_nxt = {30'h0000_0000, ist_r};
      hit_ien: prdata_nxt = {30'h0000_0000, ien_r};
      default: prdata_nxt = NMH_RST_WORD;
    endcase
  end
  assign pslverr_nxt = access && !mapped;

  // operand, option and interrupt enable registers
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      src1_r <= NMH_RST_WORD;
      src2_r <= NMH_RST_WORD;
      opt_r <= '0;
      ien_r <= '0;
    end else begin
      if (wr && hit_src1) src1_r <= PWDATA;
      if (wr && hit_src2) src2_r <= PWDATA;
      if (wr && hit_ctrl) opt_r <= '{sat: sat_w, ove: ove_w, rec: rec_w};
      if (wr && hit_ien) ien_r <= PWDATA[NMH_IRQ_W-1:0];
    end
  end

  // architectural state: accumulator, flags, condition field, interrupt status
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      dest_r <= NMH_RST_WORD;
      so_r <= 1'b0;
      ov_r <= 1'b0;
      cond_r <= NMH_RST_COND;
      ist_r <= '0;
    end else begin
      dest_r <= dest_nxt;
      so_r <= so_nxt;
      ov_r <= (wr && hit_flag && !go) ? PWDATA[NMH_FLAG_OV] : ov_nxt;
      cond_r <= cond_nxt;
      ist_r <= ist_nxt;
    end
  end

  // bus answer and interrupt, all registered; pready pulses one cycle
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      PRDATA <= NMH_RST_WORD;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      PREADY <= access && !PREADY;
      PSLVERR <= pslverr_nxt && !PREADY;
      if (rd && !PREADY) PRDATA <= prdata_nxt;
      IRQ <= |(ist_nxt & ien_r);
    end
  end
endmodule

// >>> dv/nmh_core_model.sv
/* apb master standing in for the core's decode logic.
   assumes a slave that answers with pready; the bench timeout ends a hang */
`timescale 1ns/1ps
module nmh_core_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0000_0000
);
  // setup cycle, then access held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// >>> dv/nmh_unit_chk.sv
/* port checker for the unit, bound below.
   assumes a master that holds each request until pready */
`timescale 1ns/1ps
module nmh_unit_chk
  import nmh_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // word-aligned places up to the clear register
  wire logic mapped = PADDR[1:0] == 2'b00 && PADDR <= NMH_OFF_ICLR;
  sequence acc_start;
    PSEL && $rose(PENABLE);
  endsequence
  sequence ien_off;
    PREADY && PWRITE && PADDR == NMH_OFF_IEN && PWDATA == 32'h0000_0000;
  endsequence
  one_wait_a: assert property (acc_start |=> PREADY) else $error("pready late");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("pready held");
  ready_access_a: assert property (PREADY |-> PSEL && PENABLE) else $error("stray pready");
  err_ready_a: assert property (PSLVERR |-> PREADY) else $error("stray pslverr");
  err_map_a: assert property (PREADY |-> PSLVERR == !mapped) else $error("pslverr wrong");
  bad_read_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  go_zero_a: assert property (PREADY && !PWRITE && PADDR == NMH_OFF_CTRL |-> !PRDATA[0])
    else $error("go bit read back");
  irq_masked_a: assert property (ien_off |-> ##2 !IRQ) else $error("irq while masked");
  reset_quiet_a: assert property (disable iff (1'b0) SRST |=> !PREADY && !IRQ)
    else $error("outputs live in reset");
endmodule
bind nmh_unit nmh_unit_chk nmh_unit_chk_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));

// >>> dv/tb_nmh_unit.sv
/* self-checking bench for the unit over apb.
   assumes the partner model in nmh_core_model drives the bus */
`timescale 1ns/1ps
module tb_nmh_unit;
  import nmh_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] flg = 2'b00; // expected overflow, summary
  logic [3:0] cnd = 4'h0;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  nmh_unit nmh_unit_i (.CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq));
  nmh_core_model nmh_core_model_i (.clk(clk_sys), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    comparisons++;
    if (s !== x) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    nmh_core_model_i.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk($sformatf("reg %h", a), x, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    nmh_core_model_i.xfer(1'b1, a, d, q, e);
  endtask
  // every variant on a signed case and on a case that underflows
  task automatic t_ops;
    logic [31:0] a, d, r;
    logic signed [31:0] p;
    logic signed [32:0] w;
    logic ov;
    for (int i = 0; i < 16; i++) begin
      a = i[3] ? 32'h7fff_0000 : 32'hfffd_1234;
      d = i[3] ? 32'h8000_0005 : 32'h0000_0009;
      p = $signed(a[31:16]) * $signed(a[31:16]);
      w = $signed({d[31], d}) - $signed({p[31], p});
      ov = w[32] != w[31];
      r = (i[0] && ov) ? (w[32] ? NMH_SAT_NEG : NMH_SAT_POS) : w[31:0];
      if (i[1]) flg = {ov, flg[0] | ov};
      if (i[2]) cnd = {r[31], !r[31] && r != 0, r == 0, flg[0]};
      wr(NMH_OFF_SRC1, a);
      wr(NMH_OFF_SRC2, a ^ 32'h0000_ffff); // low half must not matter
      wr(NMH_OFF_DEST, d);
      wr(NMH_OFF_CTRL, {28'h0, i[2:0], 1'b1});
      rd(NMH_OFF_DEST, r);
      rd(NMH_OFF_FLAG, {30'h0, flg});
      rd(NMH_OFF_COND, {28'h0, cnd});
    end
  endtask
  // unmapped place is refused, then the interrupt is raised, masked, cleared
  task automatic t_bus_irq;
    for (int k = 0; k < 4; k++) rd(8'(4 * k), 32'h0000_0000);
    wr(8'h24, 32'hffff_ffff);
    chk("wr err", 32'h1, {31'h0, e});
    wr(NMH_OFF_IEN, 32'h0000_0001);
    rd(NMH_OFF_IST, 32'h0000_0000);
    chk("irq idle", 32'h0, {31'h0, irq});
    t_ops;
    rd(NMH_OFF_IST, 32'h0000_0003);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(NMH_OFF_IEN, 32'h0000_0000);
    rd(8'h24, 32'h0000_0000);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(NMH_OFF_IEN, 32'h0000_0003);
    wr(NMH_OFF_ICLR, 32'h0000_0003);
    rd(NMH_OFF_IST, 32'h0000_0000);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask
  // sticky summary survives a clean overflow-enabled launch, then software clears it
  task automatic t_flags;
    wr(NMH_OFF_SRC1, 32'hfffd_0000);
    wr(NMH_OFF_SRC2, 32'hfffd_0000);
    wr(NMH_OFF_DEST, 32'h0000_0009);
    wr(NMH_OFF_CTRL, 32'h0000_0005);
    rd(NMH_OFF_CTRL, 32'h0000_0004);
    rd(NMH_OFF_DEST, 32'h0000_0000);
    rd(NMH_OFF_FLAG, 32'h0000_0001);
    rd(NMH_OFF_COND, {28'h0, cnd});
    wr(NMH_OFF_FLAG, 32'h0000_0000);
    rd(NMH_OFF_FLAG, 32'h0000_0000);
  endtask
  task final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // hang guard, far above the roughly 540 cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    t_bus_irq;
    t_flags;
    final_report;
  end
endmodule
